// *** testbench/hbs_host.sv ***
`timescale 1ns/10ps
module hbs_host (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// command from the bench
	input wire logic run_req,
	// drive side
	input wire logic motion_ref_permit,
	input wire logic [1:0] brake_release_out,
	output logic servo_on_pin,
	// relay and reference activity
	output logic relay_closed,
	output int ref_count
);
	// servo-on follows the request one edge later
	always @(posedge ref_clk) begin
		servo_on_pin <= run_req;
	end
	// relay coil closes on either routed pair
	assign relay_closed = |brake_release_out;
	// references only once the drive grants them
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			ref_count <= 0;
		end else if (run_req && motion_ref_permit && relay_closed) begin
			ref_count <= ref_count + 1;
		end
	end
endmodule : hbs_host

// *** testbench/hbs_sequencer_chk.sv ***
`timescale 1ns/10ps
module hbs_chk #(
	parameter int TICK_CYCLES = hbs_pkg::MS_CYCLES
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// bus answers
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// drive side
	input wire logic servo_on_pin,
	input wire logic fwd_overtravel_pin,
	input wire logic rev_overtravel_pin,
	input wire logic alarm_active,
	input wire logic [15:0] motor_speed,
	input wire logic [1:0] brake_release_out,
	input wire logic motor_power_on,
	input wire logic motion_ref_permit
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic [31:0] run_cnt;
	logic [31:0] next_run_cnt;
	// cycles of motor power, wide so it never wraps in a run
	always_comb begin
		next_run_cnt = motor_power_on ? run_cnt + 32'h1 : 32'h0;
	end
	always_ff @(posedge ref_clk) begin
		run_cnt <= rst_n ? next_run_cnt : 32'h0;
	end
	property p_route;
		!(brake_release_out[0] && brake_release_out[1]);
	endproperty
	a_route: assert property (p_route) else $error("two pairs on");
	property p_alarm;
		alarm_active && motor_speed == 16'h0000 |->
			##[1:3] (brake_release_out == 2'h0 && !motor_power_on);
	endproperty
	a_alarm: assert property (p_alarm) else $error("alarm kept");
	property p_servo;
		!servo_on_pin [*3] ##0 motor_speed == 16'h0000 |->
			##[0:3] brake_release_out == 2'h0;
	endproperty
	a_servo: assert property (p_servo) else $error("servo off kept");
	property p_rise;
		$rose(|brake_release_out) |-> motor_power_on;
	endproperty
	a_rise: assert property (p_rise) else $error("release unpowered");
	// permit only once the wait after release has run
	property p_permit;
		$rose(motion_ref_permit) |-> int'(run_cnt) >= 49 * TICK_CYCLES
			&& int'(run_cnt) <= 51 * TICK_CYCLES + 4;
	endproperty
	a_permit: assert property (p_permit) else $error("permit time");
	property p_ot;
		(fwd_overtravel_pin || rev_overtravel_pin) && servo_on_pin
			&& $past(servo_on_pin, 4) && !alarm_active
			&& !$past(alarm_active) && |brake_release_out && motor_power_on
			|=> $stable(brake_release_out);
	endproperty
	a_ot: assert property (p_ot) else $error("overtravel moved brake");
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped");
	property p_bonce;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_bonce: assert property (p_bonce) else $error("response repeated");
endmodule : hbs_chk

bind hbs_sequencer hbs_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
	.ref_clk(ref_clk), .rst_n(rst_n), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.servo_on_pin(servo_on_pin), .fwd_overtravel_pin(fwd_overtravel_pin),
	.rev_overtravel_pin(rev_overtravel_pin), .alarm_active(alarm_active),
	.motor_speed(motor_speed), .brake_release_out(brake_release_out),
	.motor_power_on(motor_power_on), .motion_ref_permit(motion_ref_permit)
);

// *** testbench/test_holding_brake_sequencer.sv ***
`timescale 1ns/10ps
module test_holding_brake_sequencer;
	localparam int T = 4;
	logic ref_clk, rst_n, aw_valid, aw_ready, w_valid, w_ready;
	logic b_valid, b_ready, ar_valid, ar_ready, r_valid, r_ready;
	logic [31:0] aw_addr, w_data, ar_addr, r_data, data;
	logic [3:0] w_strb;
	logic [1:0] b_resp, r_resp, brake, resp;
	logic servo, fwd_ot, rev_ot, alarm, power, permit, run_req, relay;
	logic [15:0] speed;
	int ref_count, errors, comparisons, cnt;
	int regs[4];

	hbs_sequencer #(.TICK_CYCLES(T)) DUT (
		.ref_clk(ref_clk), .rst_n(rst_n),
		.s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_valid),
		.s_axi_awready(aw_ready), .s_axi_wdata(w_data),
		.s_axi_wstrb(w_strb), .s_axi_wvalid(w_valid),
		.s_axi_wready(w_ready), .s_axi_bresp(b_resp),
		.s_axi_bvalid(b_valid), .s_axi_bready(b_ready),
		.s_axi_araddr(ar_addr), .s_axi_arvalid(ar_valid),
		.s_axi_arready(ar_ready), .s_axi_rdata(r_data),
		.s_axi_rresp(r_resp), .s_axi_rvalid(r_valid),
		.s_axi_rready(r_ready), .servo_on_pin(servo),
		.fwd_overtravel_pin(fwd_ot), .rev_overtravel_pin(rev_ot),
		.alarm_active(alarm), .motor_speed(speed),
		.brake_release_out(brake), .motor_power_on(power),
		.motion_ref_permit(permit)
	);
	hbs_host host (
		.ref_clk(ref_clk), .rst_n(rst_n), .run_req(run_req),
		.motion_ref_permit(permit), .brake_release_out(brake),
		.servo_on_pin(servo), .relay_closed(relay), .ref_count(ref_count)
	);

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t bus got %h exp %h", $time, got, exp);
		end
	endtask : chk_bus

	task automatic chk_out(input logic [1:0] got, input logic [1:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t out got %h exp %h", $time, got, exp);
		end
	endtask : chk_out

	// sample at the falling edge, where everything has settled
	task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		aw_addr <= a;
		w_data <= d;
		aw_valid <= 1'b1;
		w_valid <= 1'b1;
		tb = 1'b0;
		while (!tb) begin
			@(negedge ref_clk);
			ta = aw_valid && aw_ready;
			tw = w_valid && w_ready;
			tb = b_valid;
			resp = b_resp;
			@(posedge ref_clk);
			if (ta) aw_valid <= 1'b0;
			if (tw) w_valid <= 1'b0;
		end
	endtask : bus_wr

	// ready raised late so the slave must hold its answer
	task automatic bus_rd(input logic [31:0] a);
		logic ta, tr, rr;
		ar_addr <= a;
		ar_valid <= 1'b1;
		tr = 1'b0;
		while (!tr) begin
			@(negedge ref_clk);
			ta = ar_valid && ar_ready;
			tr = r_valid && r_ready;
			data = r_data;
			resp = r_resp;
			// decided on settled values, not in the launching time step
			rr = r_valid && !r_ready;
			@(posedge ref_clk);
			if (ta) ar_valid <= 1'b0;
			r_ready <= rr;
		end
	endtask : bus_rd

	task automatic rd_chk(input logic [31:0] a, input logic [31:0] d,
		input logic [1:0] r);
		bus_rd(a);
		chk_bus(data, d);
		chk_out(resp, r);
	endtask : rd_chk

	// bounded wait, ends at a falling edge
	task automatic until_lvl(ref logic s, input logic v);
		cnt = 0;
		do begin
			@(negedge ref_clk);
			cnt++;
		end while (s !== v && cnt < 4000);
		// a wait that runs out is a mismatch, not a silent pass
		if (s !== v) begin
			errors++;
			$display("[FAIL] %0t wait got %h exp %h", $time, s, v);
		end
	endtask : until_lvl

	function automatic logic [1:0] route(input int al);
		return al == 1 ? 2'h1 : al == 2 ? 2'h2 : 2'h0;
	endfunction : route

	task automatic conclude();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : conclude

	initial begin
		repeat (20000) @(posedge ref_clk);
		errors++;
		conclude();
	end

	initial begin
		{rst_n, aw_valid, w_valid, ar_valid, r_ready, run_req} = 6'h00;
		{fwd_ot, rev_ot, alarm, b_ready} = 4'h1;
		{aw_addr, w_data, ar_addr, speed} = 112'h0;
		w_strb = 4'hF;
		regs = '{0, 0, 100, 500};
		void'($urandom(92231));
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		// settings after reset, then refused places
		for (int i = 0; i < 4; i++) begin
			rd_chk(32'(4 * i), 32'(regs[i]), 2'h0);
		end
		rd_chk(32'h14, 32'h0, 2'h2);
		bus_wr(32'h10, 32'h1);
		chk_out(resp, 2'h2);
		// allocation codes 0 to 3, each ending in a stop at standstill
		for (int al = 0; al < 4; al++) begin
			regs[1] = 1 + $urandom % 6;
			bus_wr(32'h0, 32'(al << 8));
			bus_wr(32'h4, 32'(regs[1]));
			rd_chk(32'h0, 32'(al << 8), 2'h0);
			run_req <= 1'b1;
			until_lvl(power, 1'b1);
			chk_out(brake, route(al));
			until_lvl(permit, 1'b1);
			chk_out({1'b0, cnt >= 49 * T && cnt <= 51 * T + 4}, 2'h1);
			@(posedge ref_clk);
			{fwd_ot, rev_ot} <= 2'(1 + $urandom % 3);
			repeat (8) @(posedge ref_clk);
			{fwd_ot, rev_ot} <= 2'h0;
			@(negedge ref_clk);
			chk_out(brake, route(al));
			@(posedge ref_clk);
			run_req <= 1'b0;
			until_lvl(power, 1'b0);
			chk_out(brake, 2'h0);
			chk_out({1'b0, cnt > (regs[1] - 1) * T
				&& cnt <= (regs[1] + 1) * T + 6}, 2'h1);
			@(posedge ref_clk);
		end
		chk_out({1'b0, ref_count > 0}, 2'h1);
		// alarm while turning: power cut, brake held for the wait
		bus_wr(32'hC, 32'h3);
		bus_wr(32'h0, 32'h200);
		run_req <= 1'b1;
		until_lvl(power, 1'b1);
		@(posedge ref_clk);
		speed <= 16'h0100;
		alarm <= 1'b1;
		until_lvl(relay, 1'b0);
		chk_out({1'b0, cnt > 2 * T && cnt <= 4 * T + 4}, 2'h1);
		chk_out({1'b0, power}, 2'h0);
		@(posedge ref_clk);
		speed <= 16'h0000;
		run_req <= 1'b0;
		repeat (4) @(posedge ref_clk);
		alarm <= 1'b0;
		// servo-off while turning: brake held until speed drops below b
		bus_wr(32'hC, 32'h64);
		run_req <= 1'b1;
		until_lvl(permit, 1'b1);
		@(posedge ref_clk);
		rd_chk(32'h10, 32'h10F, 2'h0);
		speed <= 16'h0100;
		run_req <= 1'b0;
		until_lvl(power, 1'b0);
		repeat (8) @(negedge ref_clk);
		chk_out(brake, 2'h2);
		@(posedge ref_clk);
		speed <= 16'h0000;
		until_lvl(relay, 1'b0);
		chk_out({1'b0, cnt == 2}, 2'h1);
		// alarm at standstill: brake at once, torque one edge later
		@(posedge ref_clk);
		run_req <= 1'b1;
		until_lvl(power, 1'b1);
		@(posedge ref_clk);
		alarm <= 1'b1;
		until_lvl(relay, 1'b0);
		chk_out({1'b0, cnt == 2}, 2'h1);
		@(negedge ref_clk);
		chk_out({1'b0, power}, 2'h0);
		@(posedge ref_clk);
		run_req <= 1'b0;
		alarm <= 1'b0;
		conclude();
	end
endmodule : test_holding_brake_sequencer

// *** verilog/hbs_axil_slave.sv ***
`timescale 1ns/10ps
module hbs_axil_slave (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// write address and data
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// read address and data
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// register file side
	output hbs_pkg::hbs_wr_t wr,
	output hbs_pkg::hbs_sel_t rd_sel,
	input wire logic [31:0] rd_data
);

	logic aw_held;
	logic [31:0] aw_addr;
	logic w_held;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic bvalid;
	logic [1:0] bresp;
	logic rvalid;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic next_aw_held;
	logic [31:0] next_aw_addr;
	logic next_w_held;
	logic [31:0] next_w_data;
	logic [3:0] next_w_strb;
	logic next_bvalid;
	logic [1:0] next_bresp;
	logic next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;
	hbs_pkg::hbs_sel_t wr_sel;

	// no new address or data while a response is still owed
	assign s_axi_awready = !aw_held && !bvalid;
	assign s_axi_wready = !w_held && !bvalid;
	assign s_axi_arready = !rvalid;
	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = bresp;
	assign s_axi_rvalid = rvalid;
	assign s_axi_rdata = rdata;
	assign s_axi_rresp = rresp;
	assign rd_sel = hbs_pkg::hbs_decode(s_axi_araddr);
	assign wr_sel = hbs_pkg::hbs_decode(aw_addr);

	// write commits one cycle after both halves are held
	always_comb begin
		wr.en = aw_held && w_held && !bvalid;
		wr.sel = wr_sel;
		wr.data = w_data;
		wr.strb = w_strb;
	end

	// channel bookkeeping
	always_comb begin
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held = w_held;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (wr.en) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			// status is read-only, so a write there is refused too
			if (wr_sel == hbs_pkg::SEL_NONE || wr_sel == hbs_pkg::SEL_STATUS) begin
				next_bresp = hbs_pkg::RESP_SLVERR;
			end else begin
				next_bresp = hbs_pkg::RESP_OKAY;
			end
		end else if (bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rdata = rd_data;
			if (rd_sel == hbs_pkg::SEL_NONE) begin
				next_rresp = hbs_pkg::RESP_SLVERR;
			end else begin
				next_rresp = hbs_pkg::RESP_OKAY;
			end
		end else if (rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			aw_held <= 1'b0;
			aw_addr <= 32'h0000_0000;
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= hbs_pkg::RESP_OKAY;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= hbs_pkg::RESP_OKAY;
		end else begin
			aw_held <= next_aw_held;
			aw_addr <= next_aw_addr;
			w_held <= next_w_held;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end

endmodule : hbs_axil_slave

// *** verilog/hbs_pkg.sv ***
package hbs_pkg;

	// register byte offsets on the AXI4-Lite bus
	localparam logic [31:0] OFF_ALLOC = 32'h0000_0000;
	localparam logic [31:0] OFF_APPLY = 32'h0000_0004;
	localparam logic [31:0] OFF_TIMB = 32'h0000_0008;
	localparam logic [31:0] OFF_TIMC = 32'h0000_000C;
	localparam logic [31:0] OFF_STATUS = 32'h0000_0010;

	// brake output allocation field inside the allocation register
	localparam int ALLOC_LSB = 8;
	localparam logic [3:0] ALLOC_NONE = 4'h0;
	localparam logic [3:0] ALLOC_PAIR1 = 4'h1;
	localparam logic [3:0] ALLOC_PAIR2 = 4'h2;

	// values after reset
	localparam logic [3:0] RST_ALLOC = 4'h0;
	localparam logic [15:0] RST_APPLY = 16'h0000;
	localparam logic [15:0] RST_TIMB = 16'h0064;
	localparam logic [15:0] RST_TIMC = 16'h01F4;

	// millisecond time base
	localparam int CLK_PERIOD_NS = 40;
	localparam int MS_TIME_NS = 1000000;
	localparam int MS_CYCLES = MS_TIME_NS / CLK_PERIOD_NS;
	// 50 ms wait before the host may send references
	localparam logic [15:0] REF_WAIT_MS = 16'h0032;

	// status register bit positions
	localparam int ST_RELEASE = 0;
	localparam int ST_POWER = 1;
	localparam int ST_PERMIT = 2;
	localparam int ST_SERVO_ON = 3;
	localparam int ST_ALARM = 4;
	localparam int ST_FWD_OT = 5;
	localparam int ST_REV_OT = 6;
	localparam int ST_STATE_LSB = 8;

	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		SEL_ALLOC,
		SEL_APPLY,
		SEL_TIMB,
		SEL_TIMC,
		SEL_STATUS,
		SEL_NONE
	} hbs_sel_t;

	typedef enum logic [1:0] {
		ST_OFF,
		ST_RUN,
		ST_STOP_STILL,
		ST_STOP_MOVE
	} hbs_state_t;

	// one accepted register write
	typedef struct packed {
		logic en;
		hbs_sel_t sel;
		logic [31:0] data;
		logic [3:0] strb;
	} hbs_wr_t;

	// synchronised pin levels
	typedef struct packed {
		logic servo_on;
		logic fwd_ot;
		logic rev_ot;
	} hbs_pins_t;

	// byte address to register select; the whole address must match an offset
	function automatic hbs_sel_t hbs_decode(input logic [31:0] addr);
		hbs_sel_t sel;
		sel = SEL_NONE;
		unique case (addr)
			OFF_ALLOC: sel = SEL_ALLOC;
			OFF_APPLY: sel = SEL_APPLY;
			OFF_TIMB: sel = SEL_TIMB;
			OFF_TIMC: sel = SEL_TIMC;
			OFF_STATUS: sel = SEL_STATUS;
			default: sel = SEL_NONE;
		endcase
		return sel;
	endfunction : hbs_decode

	// byte-lane merge of a write into an old value
	function automatic logic [31:0] hbs_merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return res;
	endfunction : hbs_merge

endpackage : hbs_pkg

// *** verilog/hbs_sequencer.sv ***
`timescale 1ns/10ps
// Function
// - alarm or servo-off applies the brake
// - output on releases, off applies brake
// - power-off moment after brake apply set by apply delay, one edge later on alarm
// - three settings time brake and power-off
// - overtravel leaves the brake released
// - output unrouted after reset until allocated
// - allocation field: none, pair one, two
module hbs_sequencer #(
	parameter int TICK_CYCLES = hbs_pkg::MS_CYCLES
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// AXI4-Lite write address and data
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// drive pins, asynchronous
	input wire logic servo_on_pin,
	input wire logic fwd_overtravel_pin,
	input wire logic rev_overtravel_pin,
	// drive logic, same clock
	input wire logic alarm_active,
	input wire logic [15:0] motor_speed,
	// brake terminals, motor power and host permit
	output logic [1:0] brake_release_out,
	output logic motor_power_on,
	output logic motion_ref_permit
);

	// register bus towards the settings
	hbs_pkg::hbs_wr_t wr;
	hbs_pkg::hbs_sel_t rd_sel;
	logic [31:0] rd_data;

	// settings
	logic [3:0] alloc_field;
	logic [15:0] apply_delay;
	logic [15:0] timing_b;
	logic [15:0] timing_c;
	logic [3:0] next_alloc_field;
	logic [15:0] next_apply_delay;
	logic [15:0] next_timing_b;
	logic [15:0] next_timing_c;

	// pin synchronisers
	hbs_pkg::hbs_pins_t pins_s1;
	hbs_pkg::hbs_pins_t pins;

	// sequencer state
	hbs_pkg::hbs_state_t state;
	hbs_pkg::hbs_state_t next_state;
	logic release_on;
	logic next_release_on;
	logic power_on;
	logic next_power_on;
	logic permit;
	logic next_permit;
	// ms time base and phase timer
	logic [14:0] tick_cnt;
	logic [14:0] next_tick_cnt;
	logic [15:0] ms_cnt;
	logic [15:0] next_ms_cnt;
	// registered drive of the two terminal pairs
	logic [1:0] term;
	logic [1:0] next_term;
	// decoded conditions
	logic tick;
	logic stop_req;
	logic moving;

	// bus slave; a write lands as a one-cycle pulse on wr
	hbs_axil_slave u_bus (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr(wr),
		.rd_sel(rd_sel),
		.rd_data(rd_data)
	);

	// two flops per pin; only the second stage is read
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pins_s1 <= '0;
			pins <= '0;
		end else begin
			pins_s1 <= {servo_on_pin, fwd_overtravel_pin, rev_overtravel_pin};
			pins <= pins_s1;
		end
	end

	// settings update through byte lanes
	always_comb begin
		logic [31:0] merged;
		merged = 32'h0000_0000;
		next_alloc_field = alloc_field;
		next_apply_delay = apply_delay;
		next_timing_b = timing_b;
		next_timing_c = timing_c;
		if (wr.en) begin
			unique case (wr.sel)
				hbs_pkg::SEL_ALLOC: begin
					merged = hbs_pkg::hbs_merge(
						{20'h00000, alloc_field, 8'h00}, wr.data, wr.strb);
					next_alloc_field = merged[hbs_pkg::ALLOC_LSB +: 4];
				end
				hbs_pkg::SEL_APPLY: begin
					merged = hbs_pkg::hbs_merge({16'h0000, apply_delay},
						wr.data, wr.strb);
					next_apply_delay = merged[15:0];
				end
				hbs_pkg::SEL_TIMB: begin
					merged = hbs_pkg::hbs_merge({16'h0000, timing_b},
						wr.data, wr.strb);
					next_timing_b = merged[15:0];
				end
				hbs_pkg::SEL_TIMC: begin
					merged = hbs_pkg::hbs_merge({16'h0000, timing_c},
						wr.data, wr.strb);
					next_timing_c = merged[15:0];
				end
				hbs_pkg::SEL_STATUS,
				hbs_pkg::SEL_NONE: begin
					// refused writes leave every setting as it was
					merged = 32'h0000_0000;
				end
			endcase
		end
	end

	// settings register; allocation takes effect at once
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			alloc_field <= hbs_pkg::RST_ALLOC;
			apply_delay <= hbs_pkg::RST_APPLY;
			timing_b <= hbs_pkg::RST_TIMB;
			timing_c <= hbs_pkg::RST_TIMC;
		end else begin
			alloc_field <= next_alloc_field;
			apply_delay <= next_apply_delay;
			timing_b <= next_timing_b;
			timing_c <= next_timing_c;
		end
	end

	// read mux; unused bits and unmapped words read zero
	always_comb begin
		rd_data = 32'h0000_0000;
		unique case (rd_sel)
			hbs_pkg::SEL_ALLOC: rd_data[hbs_pkg::ALLOC_LSB +: 4] = alloc_field;
			hbs_pkg::SEL_APPLY: rd_data[15:0] = apply_delay;
			hbs_pkg::SEL_TIMB: rd_data[15:0] = timing_b;
			hbs_pkg::SEL_TIMC: rd_data[15:0] = timing_c;
			hbs_pkg::SEL_STATUS: begin
				// live view of the sequence for the host
				rd_data[hbs_pkg::ST_RELEASE] = release_on;
				rd_data[hbs_pkg::ST_POWER] = power_on;
				rd_data[hbs_pkg::ST_PERMIT] = permit;
				rd_data[hbs_pkg::ST_SERVO_ON] = pins.servo_on;
				rd_data[hbs_pkg::ST_ALARM] = alarm_active;
				rd_data[hbs_pkg::ST_FWD_OT] = pins.fwd_ot;
				rd_data[hbs_pkg::ST_REV_OT] = pins.rev_ot;
				rd_data[hbs_pkg::ST_STATE_LSB +: 2] = state;
			end
			hbs_pkg::SEL_NONE: rd_data = 32'h0000_0000;
		endcase
	end

	// overtravel is deliberately not a stop cause here
	assign stop_req = !pins.servo_on || alarm_active;
	// speed at or above setting b counts as still turning
	assign moving = motor_speed >= timing_b;
	assign tick = tick_cnt == 15'(TICK_CYCLES - 1);

	// stop sequence; the ms base restarts with each phase so delays are exact
	always_comb begin
		next_state = state;
		next_release_on = release_on;
		next_power_on = power_on;
		next_permit = permit;
		// ms base free-runs unless a phase restarts it
		next_tick_cnt = tick ? 15'h0000 : tick_cnt + 15'h0001;
		next_ms_cnt = ms_cnt;
		if (tick && ms_cnt != 16'hFFFF) begin
			next_ms_cnt = ms_cnt + 16'h0001;
		end
		// limitation: a stop sequence runs to off before any restart
		unique case (state)
			hbs_pkg::ST_OFF: begin
				// brake held and torque off until servo-on without alarm
				next_release_on = 1'b0;
				next_power_on = 1'b0;
				next_permit = 1'b0;
				if (!stop_req) begin
					next_state = hbs_pkg::ST_RUN;
					next_release_on = 1'b1;
					next_power_on = 1'b1;
					next_tick_cnt = 15'h0000;
					next_ms_cnt = 16'h0000;
				end
			end
			hbs_pkg::ST_RUN: begin
				// host may move only after the release wait
				if (ms_cnt >= hbs_pkg::REF_WAIT_MS) begin
					next_permit = 1'b1;
				end
				if (stop_req) begin
					next_permit = 1'b0;
					next_tick_cnt = 15'h0000;
					next_ms_cnt = 16'h0000;
					if (moving) begin
						// cut torque now, hold brake open until slow
						next_state = hbs_pkg::ST_STOP_MOVE;
						next_power_on = 1'b0;
					end else begin
						next_state = hbs_pkg::ST_STOP_STILL;
						next_release_on = 1'b0;
					end
				end
			end
			hbs_pkg::ST_STOP_STILL: begin
				// motor holds torque while the brake engages mechanically
				// trade-off: an alarm skips the apply delay to drop torque
				if (alarm_active || ms_cnt >= apply_delay) begin
					next_state = hbs_pkg::ST_OFF;
					next_power_on = 1'b0;
				end
			end
			hbs_pkg::ST_STOP_MOVE: begin
				// whichever comes first: speed low or wait time c spent
				if (!moving || ms_cnt >= timing_c) begin
					next_state = hbs_pkg::ST_OFF;
					next_release_on = 1'b0;
				end
			end
		endcase
		// routing; unknown field values leave both pairs open
		next_term[0] = next_release_on && alloc_field == hbs_pkg::ALLOC_PAIR1;
		next_term[1] = next_release_on && alloc_field == hbs_pkg::ALLOC_PAIR2;
	end

	// sequencer registers; the outputs come straight from these
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state <= hbs_pkg::ST_OFF;
			release_on <= 1'b0;
			power_on <= 1'b0;
			permit <= 1'b0;
			tick_cnt <= 15'h0000;
			ms_cnt <= 16'h0000;
			term <= 2'h0;
		end else begin
			state <= next_state;
			release_on <= next_release_on;
			power_on <= next_power_on;
			permit <= next_permit;
			tick_cnt <= next_tick_cnt;
			ms_cnt <= next_ms_cnt;
			term <= next_term;
		end
	end

	// flop outputs, so the relay never sees a decode glitch
	assign brake_release_out = term;
	assign motor_power_on = power_on;
	assign motion_ref_permit = permit;

endmodule : hbs_sequencer
